// ===== rtl/cfs_params.svh
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH
// configuration word layout, 14 bits
`define CFS_WORD_W        14
`define CFS_CFG_ADDR      14'h2007
`define CFS_SPACE_LO      14'h2000
`define CFS_SPACE_HI      14'h3FFF
`define CFS_OSC_LSB       0
`define CFS_OSC_W         3
`define CFS_WDT_BIT       3
`define CFS_POWERUP_DELAY_TIMER_BIT      4
`define CFS_MCLR_BIT      7
`define CFS_CP_A_LSB      5
`define CFS_CP_B_LSB      8
`define CFS_CP_C_LSB      10
`define CFS_CP_D_LSB      12
`define CFS_CP_W          2
`define CFS_CP_OFF        2'h3
`define CFS_ERASED_WORD   14'h3FFF
// oscillator select codes
`define CFS_OSC_LP        3'h0
`define CFS_OSC_XT        3'h1
`define CFS_OSC_HS        3'h2
`define CFS_OSC_RSVD      3'h3
`define CFS_OSC_INT_IO    3'h4
`define CFS_OSC_INT_CLK   3'h5
`define CFS_OSC_EXT_IO    3'h6
`define CFS_OSC_EXT_CLK   3'h7
// timing
`define CFS_CLK_NS        8
`define CFS_POWERUP_DELAY_TIMER_MS       72
`define CFS_OST_CYCLES    1024
`define CFS_WDT_W         16
`endif

// ===== rtl/cfs_pkg.sv
package cfs_pkg;
    typedef enum logic [2:0] {
        CFS_LP  = 3'h0,
        CFS_XT  = 3'h1,
        CFS_HS  = 3'h2,
        CFS_BAD = 3'h3,
        CFS_INT = 3'h4,
        CFS_EXT = 3'h6
    } cfs_osc_type;

    typedef struct packed {
        cfs_osc_type osc_mode;
        logic        clock_output_pin_en;
        logic        wdt_en;
        logic        powerup_delay_timer_en;
        logic        mclr_pin_en;
        logic [1:0]  cp_level;
        logic        cp_valid;
    } cfs_cfg_type;

    typedef enum logic [1:0] {
        CFS_S_LOAD = 2'h0,
        CFS_S_POWERUP_DELAY_TIMER = 2'h1,
        CFS_S_OST  = 2'h3,
        CFS_S_RUN  = 2'h2
    } cfs_state_type;
endpackage

// ===== rtl/cfs_wdt_counter.sv
`timescale 1ns/10ps
`include "cfs_params.svh"
// watchdog counter, run on its own rc oscillator tick, not the system clock enable
module cfs_wdt_counter #(
    parameter int WIDTH = `CFS_WDT_W
) (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic nrst_i,
    // control
    input  wire logic enable_i,
    input  wire logic rc_tick_i,
    input  wire logic clear_i,
    // status
    output logic      timeout_o
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic             timeout_nxt;

    assign count_nxt   = (clear_i || !enable_i) ? '0
                       : (rc_tick_i ? count_r + 1'b1 : count_r);
    assign timeout_nxt = enable_i && rc_tick_i && !clear_i && (&count_r);

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            count_r   <= '0;
            timeout_o <= 1'b0;
        end
        else
        begin
            count_r   <= count_nxt;
            timeout_o <= timeout_nxt;
        end
    end

    a_wdt_off_quiet: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !enable_i |=> !timeout_o)
        else $error("watchdog timed out while disabled");
    a_wdt_needs_tick: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !rc_tick_i |=> !timeout_o)
        else $error("watchdog advanced without rc tick");
endmodule

// ===== rtl/cfs_startup.sv
`timescale 1ns/10ps
`include "cfs_params.svh"
// How it works
// - programmed bit reads zero, erased reads one
// - configuration word lives at address 2007h
// - config space reachable only in programming mode
// - only the fuse bit and chip reset disable the watchdog
// - watchdog ticks from its own rc oscillator
// - oscillator timer holds reset until crystal stable
// - power-up delay 72 ms, power-up only
// - wake on reset, watchdog, or enabled interrupt
// - decode three-bit oscillator select at bits 2-0
// - rc modes pick clock output or general pin
module cfs_startup
    import cfs_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_CYCLES = (`CFS_POWERUP_DELAY_TIMER_MS * 1000000) / `CFS_CLK_NS,
    parameter int OST_CYCLES  = `CFS_OST_CYCLES
) (
    // clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     nrst_i,
    // programmer port
    input  wire logic                     prog_mode_i,
    input  wire logic                     prog_wr_i,
    input  wire logic [`CFS_WORD_W-1:0]   prog_addr_i,
    input  wire logic [`CFS_WORD_W-1:0]   prog_wdata_i,
    output logic [`CFS_WORD_W-1:0]        prog_rdata_o,
    // reset sources and oscillator start-up tick
    input  wire logic                     power_up_i,
    input  wire logic                     master_reset_pin_i,
    input  wire logic                     osc_clock_tick_i,
    // sleep and watchdog
    input  wire logic                     sleep_req_i,
    input  wire logic                     irq_pending_i,
    input  wire logic                     wdt_rc_tick_i,
    input  wire logic                     wdt_clear_i,
    // status
    output cfs_pkg::cfs_cfg_type          cfg_o,
    output logic                          chip_reset_o,
    output logic                          sleeping_o,
    output logic                          wdt_timeout_o,
    output logic                          clock_output_pin_o
);
    import cfs_pkg::*;

    localparam int PW = $clog2(POWERUP_DELAY_TIMER_CYCLES + 1);
    localparam int OW = $clog2(OST_CYCLES + 1);

    logic [`CFS_WORD_W-1:0] word_r;
    logic [`CFS_WORD_W-1:0] word_nxt;
    cfs_cfg_type            cfg_r;
    cfs_cfg_type            cfg_nxt;
    cfs_state_type          state_r;
    cfs_state_type          state_nxt;
    logic [PW-1:0]          powerup_delay_timer_cnt_r;
    logic [OW-1:0]          ost_cnt_r;
    logic                   sleep_r;
    logic                   por_seen_r;
    logic                   wdt_to;
    logic                   hit_cfg;
    logic                   in_space;
    logic                   ext_reset;
    logic                   crystal;
    logic                   cp_agree;
    logic [1:0]             cp_a;
    logic [1:0]             cp_b;
    logic [1:0]             cp_c;
    logic [1:0]             cp_d;
    logic [2:0]             osc_code;

    // oscillator decode, used for cfg only; crystal timer gating compares the raw select code
    function automatic cfs_osc_type decode_osc(input logic [2:0] code);
        case (code)
            `CFS_OSC_LP:      decode_osc = CFS_LP;
            `CFS_OSC_XT:      decode_osc = CFS_XT;
            `CFS_OSC_HS:      decode_osc = CFS_HS;
            `CFS_OSC_INT_IO,
            `CFS_OSC_INT_CLK: decode_osc = CFS_INT;
            `CFS_OSC_EXT_IO,
            `CFS_OSC_EXT_CLK: decode_osc = CFS_EXT;
            default:          decode_osc = CFS_BAD;
        endcase
    endfunction

    // programmer access only in programming mode
    assign in_space  = prog_addr_i >= `CFS_SPACE_LO;
    assign hit_cfg   = prog_mode_i && in_space && (prog_addr_i == `CFS_CFG_ADDR);
    // programming only clears bits; erased cells stay one
    assign word_nxt  = (hit_cfg && prog_wr_i) ? (word_r & prog_wdata_i) : word_r;

    assign osc_code  = word_r[`CFS_OSC_LSB +: `CFS_OSC_W];
    assign crystal   = (osc_code == `CFS_OSC_LP) || (osc_code == `CFS_OSC_XT)
                    || (osc_code == `CFS_OSC_HS);
    assign cp_a      = word_r[`CFS_CP_A_LSB +: `CFS_CP_W];
    assign cp_b      = word_r[`CFS_CP_B_LSB +: `CFS_CP_W];
    assign cp_c      = word_r[`CFS_CP_C_LSB +: `CFS_CP_W];
    assign cp_d      = word_r[`CFS_CP_D_LSB +: `CFS_CP_W];
    assign cp_agree  = (cp_a == cp_b) && (cp_a == cp_c) && (cp_a == cp_d);

    always_comb
    begin
        cfg_nxt             = cfg_r;
        cfg_nxt.osc_mode    = decode_osc(osc_code);
        cfg_nxt.clock_output_pin_en   = osc_code[2] && osc_code[0];
        cfg_nxt.wdt_en      = word_r[`CFS_WDT_BIT];
        cfg_nxt.powerup_delay_timer_en     = !word_r[`CFS_POWERUP_DELAY_TIMER_BIT];
        cfg_nxt.mclr_pin_en = word_r[`CFS_MCLR_BIT];
        cfg_nxt.cp_level    = cp_a;
        // erased pairs mean no protection at all
        cfg_nxt.cp_valid    = cp_agree && (cp_a != `CFS_CP_OFF);
    end

    // master reset pin only counts when its fuse enables it
    assign ext_reset = master_reset_pin_i && cfg_r.mclr_pin_en;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            CFS_S_LOAD: state_nxt = (cfg_nxt.powerup_delay_timer_en && !por_seen_r) ? CFS_S_POWERUP_DELAY_TIMER
                                  : (crystal ? CFS_S_OST : CFS_S_RUN);
            CFS_S_POWERUP_DELAY_TIMER: if (powerup_delay_timer_cnt_r == PW'(POWERUP_DELAY_TIMER_CYCLES - 1))
                            state_nxt = crystal ? CFS_S_OST : CFS_S_RUN;
            // the count only completes on a real oscillator edge
            CFS_S_OST:  if (osc_clock_tick_i && ost_cnt_r == OW'(OST_CYCLES - 1))
                            state_nxt = CFS_S_RUN;
            CFS_S_RUN:  ;
        endcase
        if (power_up_i || ext_reset || prog_mode_i)
            state_nxt = CFS_S_LOAD;
    end

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            word_r     <= `CFS_ERASED_WORD;
            cfg_r      <= '0;
            state_r    <= CFS_S_LOAD;
            por_seen_r <= 1'b0;
        end
        else
        begin
            word_r  <= word_nxt;
            state_r <= state_nxt;
            // fields only follow the word while in the load state
            if (state_r == CFS_S_LOAD)
                cfg_r <= cfg_nxt;
            // power-up delay is consumed once per power cycle
            if (power_up_i)
                por_seen_r <= 1'b0;
            else if (state_r == CFS_S_RUN)
                por_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i || state_r != CFS_S_POWERUP_DELAY_TIMER)
            powerup_delay_timer_cnt_r <= '0;
        else
            powerup_delay_timer_cnt_r <= powerup_delay_timer_cnt_r + 1'b1;
        if (!nrst_i || state_r != CFS_S_OST)
            ost_cnt_r <= '0;
        else if (osc_clock_tick_i)
            ost_cnt_r <= ost_cnt_r + 1'b1;
    end

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
            sleep_r <= 1'b0;
        else if (ext_reset || wdt_to || irq_pending_i || state_r != CFS_S_RUN)
            sleep_r <= 1'b0;
        else if (sleep_req_i)
            sleep_r <= 1'b1;
    end

    cfs_wdt_counter u_wdt (
        .clock_i   (clock_i),
        .nrst_i    (nrst_i),
        .enable_i  (cfg_r.wdt_en && state_r == CFS_S_RUN),
        .rc_tick_i (wdt_rc_tick_i),
        .clear_i   (wdt_clear_i),
        .timeout_o (wdt_to)
    );

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
            prog_rdata_o <= '0;
        else
            prog_rdata_o <= hit_cfg ? word_r : '0;
    end

    assign cfg_o              = cfg_r;
    assign chip_reset_o       = (state_r != CFS_S_RUN);
    assign sleeping_o         = sleep_r;
    assign wdt_timeout_o      = wdt_to;
    assign clock_output_pin_o = cfg_r.clock_output_pin_en && !chip_reset_o;

    a_prog_gate: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !prog_mode_i |=> $stable(word_r))
        else $error("config word changed outside programming mode");
    a_erase_only_clear: assert property (@(posedge clock_i) disable iff (!nrst_i)
        1'b1 |=> ((word_r & ~$past(word_r)) == '0))
        else $error("config bit went from programmed to erased");
    a_cfg_frozen_run: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_r == CFS_S_RUN) && $past(state_r == CFS_S_RUN) |-> $stable(cfg_r))
        else $error("config fields changed in run");
    a_ost_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_r == CFS_S_OST) && !osc_clock_tick_i && !power_up_i && !ext_reset
        && !prog_mode_i |=> state_r == CFS_S_OST)
        else $error("left oscillator wait without tick");
    a_powerup_delay_timer_skip_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_r == CFS_S_LOAD) && !cfg_nxt.powerup_delay_timer_en |=> state_r != CFS_S_POWERUP_DELAY_TIMER)
        else $error("power-up delay ran while disabled");
    a_wake_irq: assert property (@(posedge clock_i) disable iff (!nrst_i)
        sleep_r && irq_pending_i |=> !sleep_r)
        else $error("interrupt did not wake from sleep");
    a_cp_disagree: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !cp_agree && state_r == CFS_S_LOAD |=> !cfg_r.cp_valid)
        else $error("protection active with mismatched pairs");
    a_clock_output_pin_mode: assert property (@(posedge clock_i) disable iff (!nrst_i)
        clock_output_pin_o |-> (cfg_r.osc_mode == CFS_INT || cfg_r.osc_mode == CFS_EXT))
        else $error("clock output in crystal mode");
endmodule

// ===== dv/cfs_prog_model.sv
`timescale 1ns/10ps
// programmer on the far side of the configuration port
module cfs_prog_model (
    // clock
    input  wire logic        clock_i,
    // programmer port
    output logic             mode_o,
    output logic             wr_o,
    output logic [13:0]      addr_o,
    output logic [13:0]      wdata_o,
    input  wire logic [13:0] rdata_i
);
    initial
    begin
        mode_o  = 1'b0;
        wr_o    = 1'b0;
        addr_o  = 14'h0000;
        wdata_o = 14'h0000;
    end

    // entering programming mode is the only way into the config space
    task automatic set_mode(input logic m);
        @(posedge clock_i);
        #1 mode_o = m;
    endtask

    // released lines go to the inverse so no stale value can look valid
    task automatic write(input logic [13:0] a, input logic [13:0] d);
        @(posedge clock_i);
        #1;
        wr_o    = 1'b1;
        addr_o  = a;
        wdata_o = d;
        @(posedge clock_i);
        #1;
        wr_o    = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
    endtask

    task automatic read(input logic [13:0] a, output logic [13:0] d);
        @(posedge clock_i);
        #1 addr_o = a;
        @(posedge clock_i);
        #1 d = rdata_i;
        addr_o = ~a;
    endtask
endmodule

// ===== dv/cfs_startup_bench.sv
`timescale 1ns/10ps
`include "cfs_params.svh"
module cfs_startup_bench;
    import cfs_pkg::*;
    localparam int POWERUP_DELAY_TIMER = 40;
    localparam int OSCILLATOR_STARTUP_TIMER  = 4;
    logic clock_i, nrst_i, prog_mode_i, prog_wr_i, power_up_i, master_reset_pin_i;
    logic osc_clock_tick_i, sleep_req_i, irq_pending_i, wdt_rc_tick_i, wdt_clear_i;
    logic [13:0]  prog_addr_i, prog_wdata_i, prog_rdata_o;
    cfs_cfg_type  cfg_o;
    logic         chip_reset_o, sleeping_o, wdt_timeout_o, clock_output_pin_o;
    logic         rc_on;
    int           n_fail, comparisons, ticks;

    cfs_startup #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER), .OST_CYCLES(OSCILLATOR_STARTUP_TIMER)) u_cfs_startup (
        .clock_i(clock_i), .nrst_i(nrst_i), .prog_mode_i(prog_mode_i),
        .prog_wr_i(prog_wr_i), .prog_addr_i(prog_addr_i), .prog_wdata_i(prog_wdata_i),
        .prog_rdata_o(prog_rdata_o), .power_up_i(power_up_i),
        .master_reset_pin_i(master_reset_pin_i), .osc_clock_tick_i(osc_clock_tick_i),
        .sleep_req_i(sleep_req_i), .irq_pending_i(irq_pending_i),
        .wdt_rc_tick_i(wdt_rc_tick_i), .wdt_clear_i(wdt_clear_i), .cfg_o(cfg_o),
        .chip_reset_o(chip_reset_o), .sleeping_o(sleeping_o),
        .wdt_timeout_o(wdt_timeout_o), .clock_output_pin_o(clock_output_pin_o));
    cfs_prog_model u_cfs_prog_model (
        .clock_i(clock_i), .mode_o(prog_mode_i), .wr_o(prog_wr_i),
        .addr_o(prog_addr_i), .wdata_o(prog_wdata_i), .rdata_i(prog_rdata_o));

    initial
    begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // rc ticks run apart from the random crystal ticks
    always @(posedge clock_i)
    begin
        #1;
        if (osc_clock_tick_i === 1'b1 && chip_reset_o === 1'b1)
            ticks++;
        osc_clock_tick_i = 1'($urandom_range(1));
        wdt_rc_tick_i    = rc_on;
    end

    function automatic cfs_cfg_type exp_cfg(input logic [13:0] w);
        cfs_cfg_type c;
        logic [2:0]  o;
        o = w[2:0];
        c.osc_mode    = cfs_osc_type'(o[2] ? {o[2:1], 1'b0} : o);
        c.clock_output_pin_en   = o[2] & o[0];
        c.wdt_en      = w[3];
        c.powerup_delay_timer_en     = ~w[4];
        c.mclr_pin_en = w[7];
        // protection needs all pairs equal, and an all-erased pair means off
        c.cp_valid    = (w[6:5] == w[9:8]) && (w[9:8] == w[11:10]) && (w[11:10] == w[13:12])
                     && (w[6:5] != 2'h3);
        c.cp_level    = w[6:5];
        return c;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic pulse(ref logic s);
        @(posedge clock_i);
        #1 s = 1'b1;
        @(posedge clock_i);
        #1 s = 1'b0;
    endtask

    task automatic wait_level(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v && n < lim)
        begin
            @(posedge clock_i);
            #1 n++;
        end
    endtask

    task automatic boot(input logic [13:0] w);
        cfs_cfg_type e;
        logic [13:0] rd;
        int          n;
        e = exp_cfg(w);
        @(posedge clock_i);
        #1 nrst_i = 1'b0;
        repeat (16) @(posedge clock_i);
        #1 nrst_i = 1'b1;
        u_cfs_prog_model.set_mode(1'b1);
        u_cfs_prog_model.read(`CFS_CFG_ADDR, rd);
        chk(rd, `CFS_ERASED_WORD);
        u_cfs_prog_model.write(`CFS_CFG_ADDR, w);
        u_cfs_prog_model.read(14'h2006, rd);
        chk(rd, 14'h0000);
        u_cfs_prog_model.set_mode(1'b0);
        u_cfs_prog_model.write(`CFS_CFG_ADDR, 14'h0000);
        u_cfs_prog_model.read(`CFS_CFG_ADDR, rd);
        chk(rd, 14'h0000);
        u_cfs_prog_model.set_mode(1'b1);
        u_cfs_prog_model.read(`CFS_CFG_ADDR, rd);
        chk(rd, w);
        u_cfs_prog_model.set_mode(1'b0);
        ticks = 0;
        pulse(power_up_i);
        wait_level(chip_reset_o, 1'b0, 500, n);
        chk(chip_reset_o, 1'b0);
        chk(cfg_o, e);
        chk(clock_output_pin_o, e.clock_output_pin_en);
        if (e.powerup_delay_timer_en)
            chk(n >= POWERUP_DELAY_TIMER, 1'b1);
        if (w[2:0] < 3'h3)
            chk(ticks >= OSCILLATOR_STARTUP_TIMER, 1'b1);
        pulse(master_reset_pin_i);
        wait_level(chip_reset_o, 1'b1, 3, n);
        chk(chip_reset_o, w[7]);
        wait_level(chip_reset_o, 1'b0, 500, n);
        chk(n < POWERUP_DELAY_TIMER, 1'b1);
        chk(cfg_o, e);
    endtask

    initial
    begin
        int n;
        nrst_i = 1'b0;
        power_up_i = 1'b0;
        master_reset_pin_i = 1'b0;
        sleep_req_i = 1'b0;
        irq_pending_i = 1'b0;
        wdt_clear_i = 1'b0;
        rc_on = 1'b0;
        n_fail = 0;
        comparisons = 0;
        void'($urandom(36930));
        boot(14'h0000);
        boot(14'h2AA5);
        $display("test corner decode done");
        for (int i = 0; i < 12; i++)
        begin
            boot(14'($urandom));
            $display("test decode %0d done", i);
        end
        boot(`CFS_ERASED_WORD);
        pulse(wdt_clear_i);
        pulse(sleep_req_i);
        chk(sleeping_o, 1'b1);
        @(posedge clock_i);
        #1 irq_pending_i = 1'b1;
        wait_level(sleeping_o, 1'b0, 4, n);
        chk(sleeping_o, 1'b0);
        irq_pending_i = 1'b0;
        pulse(sleep_req_i);
        chk(sleeping_o, 1'b1);
        pulse(master_reset_pin_i);
        chk(sleeping_o, 1'b0);
        wait_level(chip_reset_o, 1'b0, 500, n);
        $display("test sleep wake done");
        pulse(sleep_req_i);
        // the watchdog needs its rc ticks; the system clock alone never wraps it
        rc_on = 1'b1;
        wait_level(wdt_timeout_o, 1'b1, 70000, n);
        chk(wdt_timeout_o, 1'b1);
        rc_on = 1'b0;
        wait_level(sleeping_o, 1'b0, 4, n);
        chk(sleeping_o, 1'b0);
        $display("test watchdog done");
        end_sim();
    end

    // boots take under two thousand cycles in all, the watchdog wrap about 65600
    initial
    begin
        #(8 * 90000);
        n_fail++;
        end_sim();
    end
endmodule
